// [rtl/ucsf_top.v]
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "ucsf_map.vh"
module ucsf_top (
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// Transmitter side
	input  wire        tx_holding_full,
	input  wire        tx_stop_start,
	output wire        tx_bit_enable,
	output wire        tx_bit_value,
	output reg  [7:0]  tx_data,
	output reg         tx_load,
	// Receiver side
	input  wire        rx_stop_sample,
	input  wire        rx_extra_in,
	input  wire        rx_stop_in,
	input  wire        rx_parity_bad,
	input  wire        rx_overrun,
	input  wire        rx_fifo_nonempty,
	input  wire [7:0]  rx_fifo_data,
	output wire        rx_enable,
	output reg         rx_pop,
	output wire        parity_enable,
	// Interrupt to processor
	output wire        port_irq
);

	reg        perr_reg;
	reg        ovr_reg;
	reg        ren_reg;
	reg        tbx_reg;
	reg        rbx_reg;
	reg        tdone_reg;
	reg        ravail_reg;
	reg        ien_reg;
	reg        pen_reg;
	reg        xbe_reg;
	reg  [7:0] rbuf_reg;
	reg        fifo_has_s1;
	reg        fifo_has_s2;
	reg        stop_s1;
	reg        stop_s2;
	reg        stop_d;
	reg        tstart_s1;
	reg        tstart_s2;
	reg        tstart_d;
	reg        hold_s1;
	reg        hold_s2;
	reg        extra_s1;
	reg        extra_s2;
	reg        stopv_s1;
	reg        stopv_s2;
	reg        pbad_s1;
	reg        pbad_s2;
	reg        ovrin_s1;
	reg        ovrin_s2;
	reg  [7:0] fdata_s1;
	reg  [7:0] fdata_s2;

	wire       acc;
	wire       wr;
	wire       rd;
	wire       wr_ctrl;
	wire       rx_event;
	wire       tx_event;
	wire [7:0] ctrl_view;
	wire       mapped;
	wire       sel_ctrl;
	wire       sel_mode;
	wire       sel_data;
	wire       sel_stat;

	function is_rise;
		input cur;
		input old;
		begin
			is_rise = cur & ~old;
		end
	endfunction

	function addr_hit;
		input [11:0] addr;
		input [11:0] offset;
		begin
			addr_hit = (addr == offset);
		end
	endfunction

	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign rd      = acc & ~pwrite;
	assign pready  = 1'b1;
	assign sel_ctrl = addr_hit(paddr, `UCSF_ADDR_CTRL);
	assign sel_mode = addr_hit(paddr, `UCSF_ADDR_MODE);
	assign sel_data = addr_hit(paddr, `UCSF_ADDR_DATA);
	assign sel_stat = addr_hit(paddr, `UCSF_ADDR_STAT);
	assign mapped  = sel_ctrl | sel_mode | sel_data | sel_stat;
	assign pslverr = acc & ~mapped;
	assign wr_ctrl = wr & sel_ctrl;

	// Event strobes crossing from the serial engine
	assign rx_event = is_rise(stop_s2, stop_d) & ren_reg;
	assign tx_event = is_rise(tstart_s2, tstart_d);

	assign rx_enable     = ren_reg;
	assign parity_enable = pen_reg;
	assign tx_bit_enable = xbe_reg & ~pen_reg;
	assign tx_bit_value  = pen_reg ? 1'b0 : tbx_reg;

	assign ctrl_view = {ovr_reg, perr_reg, ~hold_s2, ren_reg,
			    tbx_reg, rbx_reg, tdone_reg, ravail_reg};

	assign port_irq = ien_reg & (tdone_reg | ravail_reg);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_s1     <= 1'b0;
			stop_s2     <= 1'b0;
			stop_d      <= 1'b0;
			tstart_s1   <= 1'b0;
			tstart_s2   <= 1'b0;
			tstart_d    <= 1'b0;
			hold_s1     <= 1'b0;
			hold_s2     <= 1'b0;
			fifo_has_s1 <= 1'b0;
			fifo_has_s2 <= 1'b0;
		end else begin
			stop_s1     <= rx_stop_sample;
			stop_s2     <= stop_s1;
			stop_d      <= stop_s2;
			tstart_s1   <= tx_stop_start;
			tstart_s2   <= tstart_s1;
			tstart_d    <= tstart_s2;
			hold_s1     <= tx_holding_full;
			hold_s2     <= hold_s1;
			fifo_has_s1 <= rx_fifo_nonempty;
			fifo_has_s2 <= fifo_has_s1;
		end
	end

	// Receive qualifiers cross with the same latency as the stop strobe
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			extra_s1 <= 1'b0;
			extra_s2 <= 1'b0;
			stopv_s1 <= 1'b0;
			stopv_s2 <= 1'b0;
			pbad_s1  <= 1'b0;
			pbad_s2  <= 1'b0;
			ovrin_s1 <= 1'b0;
			ovrin_s2 <= 1'b0;
		end else begin
			extra_s1 <= rx_extra_in;
			extra_s2 <= extra_s1;
			stopv_s1 <= rx_stop_in;
			stopv_s2 <= stopv_s1;
			pbad_s1  <= rx_parity_bad;
			pbad_s2  <= pbad_s1;
			ovrin_s1 <= rx_overrun;
			ovrin_s2 <= ovrin_s1;
		end
	end

	// FIFO head byte is held stable by the engine while nonempty
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fdata_s1 <= 8'h00;
			fdata_s2 <= 8'h00;
		end else begin
			fdata_s1 <= rx_fifo_data;
			fdata_s2 <= fdata_s1;
		end
	end

	// Control bits written by software
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ren_reg <= 1'b0;
			tbx_reg <= 1'b0;
			ien_reg <= 1'b0;
			pen_reg <= 1'b0;
			xbe_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ren_reg <= pwdata[`UCSF_BIT_REN];
				tbx_reg <= pwdata[`UCSF_BIT_TBX];
			end
			if (wr & (paddr == `UCSF_ADDR_MODE)) begin
				ien_reg <= pwdata[`UCSF_BIT_IEN];
				pen_reg <= pwdata[`UCSF_BIT_PEN];
				xbe_reg <= pwdata[`UCSF_BIT_XBE];
			end
		end
	end

	// Hardware-set flags; a set in the clear cycle wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_reg <= 1'b0;
		end else if (rx_event & pen_reg & pbad_s2) begin
			perr_reg <= 1'b1;
		end else if (wr_ctrl & ~pwdata[`UCSF_BIT_PERR]) begin
			perr_reg <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_reg <= 1'b0;
		end else if (rx_event & ovrin_s2) begin
			ovr_reg <= 1'b1;
		end else if (wr_ctrl & ~pwdata[`UCSF_BIT_OVR]) begin
			ovr_reg <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdone_reg <= 1'b0;
		end else if (tx_event) begin
			tdone_reg <= 1'b1;
		end else if (wr_ctrl) begin
			tdone_reg <= pwdata[`UCSF_BIT_TDONE];
		end
	end

	// Cannot be cleared while the FIFO still holds a byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ravail_reg <= 1'b0;
		end else if (rx_event | fifo_has_s2) begin
			ravail_reg <= 1'b1;
		end else if (wr_ctrl) begin
			ravail_reg <= pwdata[`UCSF_BIT_RAVAIL];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rbx_reg <= 1'b0;
		end else if (rx_event) begin
			rbx_reg <= xbe_reg ? extra_s2 : stopv_s2;
		end else if (wr_ctrl) begin
			rbx_reg <= pwdata[`UCSF_BIT_RBX];
		end
	end

	// Data buffer: writes load the transmitter, reads pop the FIFO
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data  <= 8'h00;
			tx_load  <= 1'b0;
			rx_pop   <= 1'b0;
			rbuf_reg <= 8'h00;
		end else begin
			tx_load <= wr & (paddr == `UCSF_ADDR_DATA);
			rx_pop  <= rd & sel_data & fifo_has_s2;
			if (wr & (paddr == `UCSF_ADDR_DATA))
				tx_data <= pwdata[7:0];
			if (rd & (paddr == `UCSF_ADDR_DATA))
				rbuf_reg <= fdata_s2;
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (paddr == `UCSF_ADDR_CTRL) begin
			prdata = {24'h000000, ctrl_view};
		end else if (paddr == `UCSF_ADDR_MODE) begin
			prdata = {29'h00000000, ien_reg, pen_reg, xbe_reg};
		end else if (paddr == `UCSF_ADDR_DATA) begin
			prdata = {24'h000000, fdata_s2};
		end else if (paddr == `UCSF_ADDR_STAT) begin
			prdata = {24'h000000, rbuf_reg};
		end
	end

endmodule

// [shared/ucsf_map.vh]
`ifndef UCSF_MAP_VH
`define UCSF_MAP_VH
`define UCSF_ADDR_CTRL     12'h000
`define UCSF_ADDR_MODE     12'h004
`define UCSF_ADDR_DATA     12'h008
`define UCSF_ADDR_STAT     12'h00C
`define UCSF_BIT_OVR       7
`define UCSF_BIT_PERR      6
`define UCSF_BIT_THRE      5
`define UCSF_BIT_REN       4
`define UCSF_BIT_TBX       3
`define UCSF_BIT_RBX       2
`define UCSF_BIT_TDONE     1
`define UCSF_BIT_RAVAIL    0
`define UCSF_BIT_IEN       2
`define UCSF_BIT_PEN       1
`define UCSF_BIT_XBE       0
`define UCSF_CTRL_RESET    8'h20
`define UCSF_MODE_RESET    3'h0
`endif

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
reg pclk=0,presetn=0,psel=0,penable=0,pwrite=0,r,e;
reg [11:0] paddr=0;
reg [31:0] pwdata=0,rd;
wire [31:0] prdata;
wire [7:0] tx_data,rx_fifo_data;
wire pready,pslverr,tx_holding_full,tx_stop_start,tx_bit_enable,tx_bit_value,tx_load;
wire rx_stop_sample,rx_extra_in,rx_stop_in,rx_parity_bad,rx_overrun,rx_fifo_nonempty;
wire rx_enable,rx_pop,parity_enable,port_irq;
integer miscompares=0,total_checks=0;
ucsf_top dut(.*);
ucsf_far_model m(.*);
initial forever #4 pclk=~pclk;
initial begin
	#100000;
	miscompares++;
	wrap_up;
end
task wrap_up;
begin
	$display("checks %0d mismatches %0d",total_checks,miscompares);
	if (miscompares==0&&total_checks>0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
end
endtask
task cmp(input [31:0] g,e);
begin
	total_checks++;
	if (g!==e) begin
		miscompares++;
		$display("ERROR %0t got %h exp %h",$time,g,e);
	end
end
endtask
task xf(input w,input [11:0] a,input [31:0] d);
begin
	psel<=1;
	pwrite<=w;
	paddr<=a;
	pwdata<=d;
	@(posedge pclk) penable<=1;
	do begin
		@(posedge pclk);
		r=pready;
		rd=prdata;
		e=pslverr;
	end while (r!==1);
	psel<=0;
	penable<=0;
	@(posedge pclk);
end
endtask
task chk(input [11:0] a,input [31:0] k,e);
begin
	xf(0,a,0);
	cmp(rd&k,e);
end
endtask
task w(input integer n);
	repeat (n) @(posedge pclk);
endtask
initial begin
	w(4);
	presetn<=1;
	w(4);
	chk(0,32'hFF,32'h20);
	xf(1,4,6);
	xf(1,0,32'h18);
	cmp({tx_bit_enable,tx_bit_value,parity_enable},1);
	xf(1,4,5);
	cmp({tx_bit_enable,tx_bit_value},3);
	xf(1,8,32'hA5);
	cmp(tx_data,32'hA5);
	chk(12'h010,32'hFFFFFFFF,0);
	cmp(e,1);
	w(1);
	chk(0,32'h20,0);
	w(12);
	chk(0,2,2);
	chk(0,32'h20,32'h20);
	cmp(port_irq,1);
	xf(1,0,32'h10);
	chk(0,3,0);
	cmp(port_irq,0);
	$display("tx test done");
	m.rxb(8'h3C,1,1,0);
	w(5);
	chk(0,5,5);
	cmp(port_irq,1);
	xf(1,0,0);
	cmp(rx_enable,0);
	chk(0,1,1);
	chk(8,32'hFF,32'h3C);
	w(3);
	xf(1,0,0);
	chk(0,1,0);
	m.rxb(8'h22,1,1,0);
	w(5);
	chk(0,5,0);
	xf(1,0,32'h10);
	xf(1,4,0);
	m.rxb(8'h11,1,0,0);
	w(5);
	chk(0,5,1);
	chk(8,32'hFF,32'h11);
	chk(12'h00C,32'hFF,32'h11);
	xf(1,4,2);
	m.rxb(8'h33,1,1,1);
	w(5);
	chk(0,32'h40,32'h40);
	xf(1,0,32'h50);
	chk(0,32'h40,32'h40);
	xf(1,0,32'h10);
	chk(0,32'h40,0);
	$display("rx test done");
	wrap_up;
end
endmodule

// [testbench/ucsf_far_model.sv]
`timescale 1ns/10ps
module ucsf_far_model(
	input wire pclk,tx_load,rx_pop,rx_enable,
	output reg tx_holding_full=0,tx_stop_start=0,rx_stop_sample=0,rx_extra_in=0,
	output reg rx_stop_in=1,rx_parity_bad=0,rx_overrun=0,rx_fifo_nonempty=0,
	output reg [7:0] rx_fifo_data=0);
// Holds the byte a while, then marks the stop bit
always @(posedge pclk) if (tx_load) begin
	tx_holding_full<=1;
	repeat (8) @(posedge pclk);
	tx_holding_full<=0;
	tx_stop_start<=1;
	repeat (3) @(posedge pclk);
	tx_stop_start<=0;
end
task rxb(input [7:0] d,input x,s,p);
begin
	if (rx_enable) begin
		rx_fifo_data<=d;
		rx_fifo_nonempty<=1;
	end
	{rx_extra_in,rx_stop_in,rx_parity_bad}<={x,s,p};
	rx_stop_sample<=1;
	repeat (4) @(posedge pclk);
	rx_stop_sample<=0;
	{rx_extra_in,rx_stop_in,rx_parity_bad}<=~{x,s,p};
end
endtask
// Popped head is gone
always @(posedge pclk) if (rx_pop) begin
	rx_fifo_nonempty<=0;
	rx_fifo_data<=~rx_fifo_data;
end
endmodule

// [testbench/ucsf_properties.sv]
`timescale 1ns/10ps
module ucsf_props(
	input wire pclk,presetn,psel,penable,pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire [7:0] rx_fifo_data,
	input wire tx_holding_full,tx_bit_enable,tx_bit_value,parity_enable,
	input wire rx_fifo_nonempty,rx_pop,port_irq);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire rd=psel&&penable&&!pwrite;
wire rc=rd&&paddr==12'h000;
AST_PE_XB: assert property (parity_enable|->!tx_bit_enable&&!tx_bit_value)
	else $error("extra bit under parity");
AST_XB: assert property (rc&&tx_bit_enable|->tx_bit_value==prdata[3])
	else $error("extra bit value");
AST_FULL: assert property (tx_holding_full[*5] ##0 rc|->!prdata[5])
	else $error("empty while full");
AST_EMPTY: assert property ((!tx_holding_full)[*5] ##0 rc|->prdata[5])
	else $error("full while empty");
AST_HOLD: assert property (rx_fifo_nonempty[*5] ##0 rc|->prdata[0])
	else $error("avail dropped");
AST_STICKY: assert property (rc ##3 rc|->(($past(prdata,3)&~prdata)&32'h43)==0)
	else $error("flag cleared");
AST_IRQ: assert property (rc&&prdata[1:0]==0|->!port_irq)
	else $error("irq without flag");
AST_POP: assert property (rd&&paddr==12'h008&&rx_fifo_nonempty
	|->prdata[7:0]==rx_fifo_data ##1 rx_pop)
	else $error("bad fifo read");
endmodule
bind ucsf_top ucsf_props u_props(.*);
